/* File: core/chopper_pwm_regs.svh */
// Register offsets, field positions, reset values and timing for the chopper config block
`ifndef CHOPPER_PWM_REGS_SVH
`define CHOPPER_PWM_REGS_SVH
`define CFG_ADDR 7'h3C
`define CFG_RESET 32'hC40C_001D
`define F_LIM_HI 31
`define F_LIM_LO 28
`define F_REG_HI 27
`define F_REG_LO 24
`define F_DIS_STST 23
`define F_MEAS_SD 22
`define F_MODE_HI 21
`define F_MODE_LO 20
`define F_AUTOGRAD 19
`define F_AUTOSCALE 18
`define F_FREQ_HI 17
`define F_FREQ_LO 16
`define F_GRAD_HI 15
`define F_GRAD_LO 8
`define F_OFS_HI 7
`define F_OFS_LO 0
`define AMPL_MAX 8'hFF
`define GRAD_STEPS 8'h08
`endif

/* File: core/chopper_pwm_pkg.sv */
// Types shared by the chopper config block
package chopper_pwm_pkg;
    typedef enum logic [1:0] {
        COIL_NORMAL = 2'h0,
        COIL_STANDSTILL_COIL_MODE = 2'h1,
        COIL_SHORT_LS = 2'h2,
        COIL_SHORT_HS = 2'h3
    } coil_mode_t;
    typedef enum logic [2:0] {
        CH_SILENT = 3'b001,
        CH_CURRENT = 3'b010,
        CH_RETURN = 3'b100
    } chop_state_t;
endpackage

/* File: core/pwm_period_gen.sv */
// Chopper cycle tick generator with selectable period
`timescale 1ns/100ps
`default_nettype none
module pwm_period_gen (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [1:0] rate_sel,
    output logic cycle_tick
);
    typedef struct packed {
        logic [9:0] cnt;
    } st_t;
    st_t s_reg, s_next;
    logic [9:0] period;
    always_comb begin
        unique case (rate_sel)
            2'h0: period = 10'd511;
            2'h1: period = 10'd341;
            2'h2: period = 10'd255;
            default: period = 10'd204;
        endcase
        s_next = s_reg;
        if (s_reg.cnt >= period) begin
            s_next.cnt = 10'h000;
        end else begin
            s_next.cnt = s_reg.cnt + 10'd1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end
    // Half of a 2/N clk period: one tick per half PWM cycle
    assign cycle_tick = ce && (s_reg.cnt >= period);
endmodule
`default_nettype wire

/* File: core/motor_chopper_pwm_config.sv */
// Motor 0 silent-chopper configuration register and amplitude control
`include "chopper_pwm_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module motor_chopper_pwm_config (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [6:0] reg_addr,
    input wire logic reg_write,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic current_mode_active,
    input wire logic standstill,
    input wire logic [4:0] hold_current_setting,
    input wire logic [4:0] run_current,
    input wire logic [4:0] actual_current_scale,
    input wire logic [19:0] step_period,
    input wire logic [7:0] regulation_target,
    output logic [7:0] pwm_amplitude,
    output logic [7:0] tuned_gradient,
    output logic regulation_enable,
    output logic slow_decay_current_measure,
    output chopper_pwm_pkg::coil_mode_t standstill_coil_mode,
    output logic [1:0] chopper_rate_select,
    output logic pwm_half_tick
);
    import chopper_pwm_pkg::*;

    typedef struct packed {
        logic [31:0] cfg;
        logic [8:0] scale_auto;
        logic [7:0] grad_auto;
        logic [7:0] step_cnt;
        logic prev_current_mode;
    } st_t;
    st_t s_reg, s_next;

    logic tick;
    pwm_period_gen period_gen (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .rate_sel(s_reg.cfg[`F_FREQ_HI:`F_FREQ_LO]),
        .cycle_tick(tick)
    );

    // Step size in half increments, so code*0.5 becomes code (9-bit fixed point, 1 fraction bit)
    function automatic logic [8:0] move_toward(input logic [8:0] cur, input logic [8:0] tgt,
                                               input logic [3:0] code);
        logic [8:0] st;
        st = {5'h00, code};
        if (tgt > cur) begin
            move_toward = ((tgt - cur) > st) ? cur + st : tgt;
        end else begin
            move_toward = ((cur - tgt) > st) ? cur - st : tgt;
        end
    endfunction

    function automatic logic [7:0] sat8(input logic [27:0] v);
        sat8 = (v > 28'd255) ? `AMPL_MAX : v[7:0];
    endfunction

    logic [3:0] lim, reg_code;
    logic autoscale, autograd, reduced, cur_reg_off;
    logic [27:0] ff_ofs, ff_grad, grad_sum;
    logic [7:0] auto_ampl;
    always_comb begin
        lim = s_reg.cfg[`F_LIM_HI:`F_LIM_LO];
        reg_code = s_reg.cfg[`F_REG_HI:`F_REG_LO];
        autoscale = s_reg.cfg[`F_AUTOSCALE];
        autograd = s_reg.cfg[`F_AUTOGRAD];
        reduced = hold_current_setting < run_current;
        cur_reg_off = s_reg.cfg[`F_DIS_STST] && standstill && reduced;
        s_next = s_reg;
        s_next.prev_current_mode = current_mode_active;
        if (reg_write && reg_addr == `CFG_ADDR) begin
            s_next.cfg = reg_wdata;
        end
        if (autoscale && tick && !cur_reg_off && reg_code != 4'h0) begin
            s_next.scale_auto = move_toward(s_reg.scale_auto, {regulation_target, 1'b0},
                                            reg_code);
        end
        // Cap only the automatic scale; gradient terms stay untouched.
        // Judged after the regulation step, so a tick on the same edge cannot overshoot.
        if (s_reg.prev_current_mode && !current_mode_active
            && s_next.scale_auto[8:5] > lim) begin
            s_next.scale_auto = {lim, 5'h1F};
        end
        if (!autograd || !autoscale) begin
            s_next.grad_auto = s_reg.cfg[`F_GRAD_HI:`F_GRAD_LO];
            s_next.step_cnt = 8'h00;
        end else if (tick && !standstill) begin
            // Slow drift toward the regulation target while moving
            s_next.step_cnt = s_reg.step_cnt + 8'd1;
            if (s_reg.step_cnt == `GRAD_STEPS) begin
                s_next.step_cnt = 8'h00;
                if (regulation_target > auto_ampl && s_reg.grad_auto != 8'hFF) begin
                    s_next.grad_auto = s_reg.grad_auto + 8'd1;
                end else if (regulation_target < auto_ampl && s_reg.grad_auto != 8'h00) begin
                    s_next.grad_auto = s_reg.grad_auto - 8'd1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg.cfg <= `CFG_RESET;
            s_reg.scale_auto <= 9'h000;
            s_reg.grad_auto <= 8'h00;
            s_reg.step_cnt <= 8'h00;
            s_reg.prev_current_mode <= 1'b0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        auto_ampl = s_reg.scale_auto[8:1];
        ff_ofs = 28'(({20'h0, s_reg.cfg[`F_OFS_HI:`F_OFS_LO]} *
                      ({23'h0, actual_current_scale} + 28'd1)) >> 5);
        ff_grad = (step_period == 20'h0) ? 28'hFF_FFFF :
                  28'(({20'h0, s_reg.cfg[`F_GRAD_HI:`F_GRAD_LO]} << 8) / {8'h0, step_period});
        grad_sum = ff_ofs + ff_grad;
    end

    assign reg_rdata = (reg_addr == `CFG_ADDR) ? s_reg.cfg : 32'h0000_0000;
    assign pwm_amplitude = autoscale ? auto_ampl : sat8(grad_sum);
    assign tuned_gradient = s_reg.grad_auto;
    assign regulation_enable = autoscale && !cur_reg_off;
    assign slow_decay_current_measure = s_reg.cfg[`F_MEAS_SD];
    assign standstill_coil_mode = (hold_current_setting == 5'h00) ?
        coil_mode_t'(s_reg.cfg[`F_MODE_HI:`F_MODE_LO]) : COIL_NORMAL;
    assign chopper_rate_select = s_reg.cfg[`F_FREQ_HI:`F_FREQ_LO];
    assign pwm_half_tick = tick;

    property ret_cap_p;
        @(posedge clk) disable iff (reset)
        (ce && s_reg.prev_current_mode && !current_mode_active)
            |=> (s_reg.scale_auto[8:5] <= $past(lim));
    endproperty
    return_cap_a: assert property (ret_cap_p) else $error("return cap missed");
    ff_clamp_a: assert property (@(posedge clk) disable iff (reset)
        (!autoscale && grad_sum > 28'd255) |-> pwm_amplitude == 8'hFF)
        else $error("feed-forward clamp wrong");
    grad_follow_a: assert property (@(posedge clk) disable iff (reset)
        (ce && !autograd) |=> tuned_gradient == $past(s_reg.cfg[15:8]))
        else $error("gradient not following");
    stst_reg_a: assert property (@(posedge clk) disable iff (reset)
        (s_reg.cfg[23] && standstill && reduced) |-> !regulation_enable)
        else $error("standstill regulation active");
    coil_mode_a: assert property (@(posedge clk) disable iff (reset)
        (hold_current_setting != 5'h00) |-> standstill_coil_mode == COIL_NORMAL)
        else $error("coil mode with hold current");
    sd_meas_a: assert property (@(posedge clk) disable iff (reset)
        slow_decay_current_measure == s_reg.cfg[22]) else $error("slow decay flag");
    step_size_a: assert property (@(posedge clk) disable iff (reset)
        (ce && tick && autoscale && !(s_reg.prev_current_mode && !current_mode_active))
            |=> ($unsigned(s_reg.scale_auto - $past(s_reg.scale_auto)) <= $past(reg_code)
              || $unsigned($past(s_reg.scale_auto) - s_reg.scale_auto) <= $past(reg_code)))
        else $error("step too large");
    reg_on_a: assert property (@(posedge clk) disable iff (reset)
        (autoscale && !s_reg.cfg[23]) |-> regulation_enable)
        else $error("regulation dropped with disable bit clear");
    write_take_a: assert property (@(posedge clk) disable iff (reset)
        (ce && reg_write && reg_addr == `CFG_ADDR) |=> s_reg.cfg == $past(reg_wdata))
        else $error("write lost");
endmodule
`default_nettype wire

/* File: dv/coil_model.sv */
// Coil bridge model: counts PWM half waves and keeps the amplitude the latest one applied
`timescale 1ns/100ps
`default_nettype none
module coil_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic pwm_half_tick,
    input wire logic [7:0] pwm_amplitude,
    output logic [15:0] half_waves,
    output logic [7:0] last_ampl
);
    // The bridges latch the amplitude once per half wave, not every clock
    always_ff @(posedge clk) begin
        if (reset) begin
            half_waves <= 16'h0000;
            last_ampl <= 8'h00;
        end else if (pwm_half_tick) begin
            half_waves <= half_waves + 16'h0001;
            last_ampl <= pwm_amplitude;
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the motor 0 chopper configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import chopper_pwm_pkg::*;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, reg_write = 1'b0, current_mode_active = 1'b0;
    logic standstill = 1'b0, regulation_enable, slow_decay_current_measure, pwm_half_tick;
    logic [6:0] reg_addr = 7'h3C;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic [4:0] hold_current_setting = 5'h03, run_current = 5'h08, actual_current_scale = 5'h00;
    logic [19:0] step_period = 20'hF_FFFF;
    logic [7:0] regulation_target = 8'h00, pwm_amplitude, tuned_gradient, last_ampl, a0;
    logic [1:0] chopper_rate_select;
    logic [15:0] half_waves;
    coil_mode_t standstill_coil_mode;
    int error_cnt = 0, comparisons = 0, cycles = 0, i, e, ofs, grad, ts;
    motor_chopper_pwm_config dut (.clk, .reset, .ce, .reg_addr, .reg_write, .reg_wdata,
        .reg_rdata, .current_mode_active, .standstill, .hold_current_setting, .run_current,
        .actual_current_scale, .step_period, .regulation_target, .pwm_amplitude,
        .tuned_gradient, .regulation_enable, .slow_decay_current_measure,
        .standstill_coil_mode, .chopper_rate_select, .pwm_half_tick);
    coil_model partner (.clk, .reset, .pwm_half_tick, .pwm_amplitude, .half_waves, .last_ampl);
    initial forever #25 clk = ~clk;
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic write_reg(input logic [6:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_addr = 7'h3C;
    endtask
    // Flags packs disable, measure, autogradient, autoscale from high to low
    function automatic logic [31:0] cfg(input int lim, code, flags, mode, freq, grad, ofs);
        return {lim[3:0], code[3:0], flags[3:2], mode[1:0], flags[1:0], freq[1:0], grad[7:0],
            ofs[7:0]};
    endfunction
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h439a));
        repeat (6) @(negedge clk);
        reset = 1'b0;
        compare(reg_rdata, 32'hC40C_001D);
        write_reg(7'h3D, 32'hFFFF_FFFF);
        reg_addr = 7'h3D;
        #1 compare(reg_rdata, 32'h0000_0000);
        reg_addr = 7'h3C;
        #1 compare(reg_rdata, 32'hC40C_001D);
        e = $urandom | 32'h0100_0000;
        write_reg(7'h3C, e);
        compare(reg_rdata, e);
        for (i = 0; i < 8; i++) begin
            hold_current_setting = (i < 4) ? 5'h00 : 5'h03;
            write_reg(7'h3C, cfg(12, 4, (i % 2) * 4 + 3, i % 4, i % 4, 0, 29));
            compare(standstill_coil_mode, (i < 4) ? i % 4 : 0);
            compare(slow_decay_current_measure, i % 2);
            compare(chopper_rate_select, i % 4);
            standstill = i[1];
            hold_current_setting = i[0] ? 5'h03 : 5'h08;
            write_reg(7'h3C, cfg(12, 4, i[2] ? 11 : 3, 0, 0, 0, 29));
            compare(regulation_enable, !(i[2] && i[1] && i[0]));
        end
        for (i = 0; i < 10; i++) begin
            ofs = $urandom % 256;
            grad = 1 + $urandom % 255;
            ts = (i == 0) ? 0 : 1 + $urandom % 2000;
            actual_current_scale = $urandom % 32;
            step_period = ts;
            hold_current_setting = $urandom % 32;
            write_reg(7'h3C, cfg(12, 4, 0, 0, 0, grad, ofs));
            repeat (2) @(negedge clk);
            e = (ts == 0) ? 255 : ofs * (actual_current_scale + 1) / 32 + grad * 256 / ts;
            compare(pwm_amplitude, (e > 255) ? 255 : e);
            compare(tuned_gradient, grad);
        end
        standstill = 1'b0;
        step_period = 20'hF_FFFF;
        hold_current_setting = 5'h03;
        regulation_target = 8'hC8;
        write_reg(7'h3C, cfg(12, 4, 1, 0, 3, 0, 0));
        @(half_waves);
        @(negedge clk);
        a0 = last_ampl;
        repeat (3) begin
            @(half_waves);
            @(negedge clk);
            compare(last_ampl, a0 + 8'h02);
            a0 = last_ampl;
        end
        regulation_target = 8'hFF;
        write_reg(7'h3C, cfg(5, 15, 1, 0, 3, 0, 0));
        while (pwm_amplitude < 8'hF0) @(negedge clk);
        current_mode_active = 1'b1;
        repeat (3) @(negedge clk);
        current_mode_active = 1'b0;
        @(negedge clk);
        compare(pwm_amplitude[7:4], 4'h5);
        report_and_stop();
    end
endmodule
`default_nettype wire
